// >>> dv/dtt_platform_model.sv
`timescale 1ns/1ps
// ********
// Platform side: pulled-up alarm wire and core supply.
// ********
module dtt_platform_model #(
    parameter int SUPPLY_OFF_CYCLES = 50
) (
    input wire logic ref_clk,
    input wire logic ext_hot,
    input wire logic thermal_alarm_n_out,
    input wire logic thermal_alarm_n_oe,
    input wire logic critical_trip_n,
    output logic thermal_alarm_n_pin,
    output logic vcc_core_on
);
    int trip_cycles = 0;
    assign thermal_alarm_n_pin = ((thermal_alarm_n_oe && !thermal_alarm_n_out) || ext_hot) ? 1'b0 : 1'b1;
    always_ff @(posedge ref_clk) begin
        if (critical_trip_n !== 1'b0) begin
            trip_cycles <= 0;
        end else if (trip_cycles < SUPPLY_OFF_CYCLES) begin
            trip_cycles <= trip_cycles + 1;
        end
    end
    assign vcc_core_on = trip_cycles < SUPPLY_OFF_CYCLES;
endmodule

// >>> dv/dtt_throttle_monitor.sv
`timescale 1ns/1ps
// ********
// Port checker for the thermal throttle.
// ********
module dtt_throttle_monitor (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] die_temp,
    input wire dtt_pkg::dtt_power_t power_state,
    input wire logic critical_trip_n,
    input wire logic core_shutdown,
    input wire logic core_clk_en,
    input wire logic snoop_active,
    input wire logic irq_to_core,
    input wire logic thermal_alarm_n_oe,
    input wire logic alarm_event,
    input wire logic [3:0] op_point,
    input wire dtt_pkg::dtt_state_t throttle_state
);
    import dtt_pkg::*;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    a_trip_on_crit: assert property (die_temp >= CRIT_TEMP && power_state <= PS_C6 |=> !critical_trip_n)
        else $error("critical trip missed");
    a_trip_sticky: assert property (!critical_trip_n |=> !critical_trip_n)
        else $error("critical trip released");
    a_trip_halts_core: assert property (!critical_trip_n |-> !core_clk_en && core_shutdown)
        else $error("core still running in trip");
    a_alarm_sleep_off: assert property ((power_state > PS_C2) [*2] |-> !thermal_alarm_n_oe)
        else $error("alarm driven in sleep");
    a_alarm_on_hot: assert property (die_temp >= TRIP_TEMP && die_temp < CRIT_TEMP && power_state <= PS_C2
        && critical_trip_n |=> thermal_alarm_n_oe)
        else $error("alarm not driven when hot");
    a_hyst_hold: assert property (thermal_alarm_n_oe && die_temp >= RELEASE_TEMP && die_temp < CRIT_TEMP
        && power_state <= PS_C2 && critical_trip_n |=> thermal_alarm_n_oe)
        else $error("alarm dropped inside hysteresis");
    a_drop_lowest: assert property (throttle_state == ST_DROP |-> op_point <= LOWEST_POINT)
        else $error("drop above lowest point");
    a_drop_no_gate: assert property (throttle_state == ST_DROP |-> core_clk_en)
        else $error("clock gated in plain drop");
    a_snoop_kept: assert property (critical_trip_n |-> snoop_active)
        else $error("snooping stopped");
    a_irq_gated: assert property (irq_to_core |-> core_clk_en)
        else $error("interrupt passed while clocks off");
    a_event_pulse: assert property (alarm_event |=> !alarm_event)
        else $error("alarm event longer than one cycle");
    c_mod: cover property (throttle_state == ST_MOD);
    c_drop_mod: cover property (throttle_state == ST_DROP_MOD);
    c_trip: cover property ($fell(critical_trip_n));
endmodule

bind dtt_throttle dtt_throttle_monitor u_dtt_throttle_monitor (.ref_clk(ref_clk), .rst_n(rst_n),
    .die_temp(die_temp), .power_state(power_state), .critical_trip_n(critical_trip_n),
    .core_shutdown(core_shutdown), .core_clk_en(core_clk_en), .snoop_active(snoop_active),
    .irq_to_core(irq_to_core), .thermal_alarm_n_oe(thermal_alarm_n_oe), .alarm_event(alarm_event),
    .op_point(op_point), .throttle_state(throttle_state));

// >>> dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import dtt_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, cm = 1'b0, fd = 1'b0, fm = 1'b0, ia = 1'b0, id = 1'b0;
    logic sw_op_req = 1'b0, irq_req = 1'b0, irq_taken = 1'b0, ext_hot = 1'b0;
    logic [7:0] die_temp = 8'h20;
    logic [4:0] throttle_ctrl = 5'h00;
    logic [3:0] sw_op_point = 4'h1, op_point;
    dtt_power_t power_state = PS_C0;
    logic pin, a_out, a_oe, critical_trip_n, core_shutdown, core_clk_en, snoop_active, irq_to_core;
    logic op_point_change, alarm_event, thermal_throttle_unit, vcc_core_on;
    dtt_state_t throttle_state;
    int failures = 0, cmp_count = 0, cycles = 0, ev_cnt = 0, on = 0;
    always #5 ref_clk = ~ref_clk;
    dtt_throttle u_dtt_throttle (.ref_clk(ref_clk), .rst_n(rst_n), .die_temp(die_temp),
        .clock_modulation_mode(cm), .frequency_drop_mode(fd), .force_modulation_with_drop(fm),
        .throttle_ctrl(throttle_ctrl), .alarm_irq_on_assert(ia), .alarm_irq_on_deassert(id),
        .power_state(power_state), .sw_op_point(sw_op_point), .sw_op_req(sw_op_req), .irq_req(irq_req),
        .irq_taken(irq_taken), .thermal_alarm_n_in(pin), .thermal_alarm_n_out(a_out),
        .thermal_alarm_n_oe(a_oe), .critical_trip_n(critical_trip_n), .core_shutdown(core_shutdown),
        .core_clk_en(core_clk_en), .snoop_active(snoop_active), .irq_to_core(irq_to_core),
        .op_point(op_point), .op_point_change(op_point_change), .alarm_event(alarm_event),
        .thermal_throttle_unit(thermal_throttle_unit), .throttle_state(throttle_state));
    dtt_platform_model #(.SUPPLY_OFF_CYCLES(50)) u_dtt_platform_model (.ref_clk(ref_clk), .ext_hot(ext_hot),
        .thermal_alarm_n_out(a_out), .thermal_alarm_n_oe(a_oe), .critical_trip_n(critical_trip_n),
        .thermal_alarm_n_pin(pin), .vcc_core_on(vcc_core_on));
    always @(posedge ref_clk) begin
        if (alarm_event === 1'b1) begin
            ev_cnt = ev_cnt + 1;
        end
        cycles = cycles + 1;
        if (cycles == 6000) begin
            failures = failures + 1;
            give_verdict();
        end
    end
    task automatic give_verdict();
        if (failures == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge ref_clk);
            #1;
        end
    endtask
    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        cmp_count = cmp_count + 1;
        if (got !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic st(input dtt_state_t exp);
        check("throttle_state", 8'(exp), 8'(throttle_state));
    endtask
    task automatic heat(input logic [7:0] t);
        die_temp = t;
        tick(3);
    endtask
    task automatic duty(input int exp);
        on = 0;
        repeat (64) begin
            tick(1);
            on = on + (core_clk_en === 1'b1);
        end
        check("clock on cycles", 8'(exp), 8'(on));
    endtask
    task automatic req(input logic [3:0] p);
        sw_op_point = p;
        sw_op_req = 1'b1;
        tick(1);
        sw_op_req = 1'b0;
        tick(2);
    endtask
    initial begin
        tick(20);
        rst_n = 1'b1;
        tick(1);
        st(ST_IDLE);
        check("op_point", 8'(OP_POINT_RESET), 8'(op_point));
        check("critical_trip_n", 8'h01, 8'(critical_trip_n));
        cm = 1'b1;
        heat(TRIP_TEMP - 8'h01);
        tick(2);
        st(ST_IDLE);
        check("alarm oe", 8'h00, 8'(a_oe));
        heat(TRIP_TEMP);
        st(ST_MOD);
        check("thermal_throttle_unit", 8'h01, 8'(thermal_throttle_unit));
        check("alarm oe", 8'h01, 8'(a_oe));
        duty(32);
        irq_req = 1'b1;
        tick(1);
        irq_req = 1'b0;
        for (int i = 0; i < 40 && irq_to_core !== 1'b1; i++) tick(1);
        check("irq_to_core", 8'h01, 8'(irq_to_core));
        irq_taken = 1'b1;
        tick(1);
        irq_taken = 1'b0;
        check("irq_to_core", 8'h00, 8'(irq_to_core));
        heat(RELEASE_TEMP);
        st(ST_MOD);
        heat(RELEASE_TEMP - 8'h01);
        st(ST_IDLE);
        check("core_clk_en", 8'h01, 8'(core_clk_en));
        check("thermal_throttle_unit", 8'h00, 8'(thermal_throttle_unit));
        for (int d = 0; d < 8; d++) begin
            throttle_ctrl = {1'b1, 3'(d), 1'b0};
            tick(4);
            duty((d == 0) ? 32 : d * 8);
        end
        throttle_ctrl = 5'h12;
        tick(4);
        duty(8);
        heat(TRIP_TEMP);
        duty(32);
        throttle_ctrl = 5'h00;
        heat(8'h20);
        cm = 1'b0;
        fd = 1'b1;
        req(4'h5);
        check("op_point", 8'h05, 8'(op_point));
        heat(TRIP_TEMP);
        st(ST_DROP);
        check("op_point", 8'(LOWEST_POINT), 8'(op_point));
        req(4'h7);
        check("op_point", 8'(LOWEST_POINT), 8'(op_point));
        heat(8'h20);
        st(ST_IDLE);
        check("op_point", 8'h07, 8'(op_point));
        heat(TRIP_TEMP);
        req(4'h0);
        check("op_point", 8'h00, 8'(op_point));
        cm = 1'b1;
        tick(3);
        st(ST_DROP);
        fm = 1'b1;
        tick(FORCE_WAIT_CYCLES + 5);
        st(ST_DROP_MOD);
        heat(8'h20);
        tick(2);
        ext_hot = 1'b1;
        tick(5);
        st(ST_DROP);
        tick(FORCE_WAIT_CYCLES + 5);
        st(ST_DROP);
        fm = 1'b0;
        fd = 1'b0;
        tick(5);
        st(ST_MOD);
        ext_hot = 1'b0;
        power_state = PS_C4;
        tick(5);
        ext_hot = 1'b1;
        tick(6);
        st(ST_IDLE);
        ext_hot = 1'b0;
        power_state = PS_C6;
        heat(TRIP_TEMP);
        check("alarm oe", 8'h00, 8'(a_oe));
        heat(8'h20);
        power_state = PS_C0;
        cm = 1'b0;
        for (int m = 0; m < 4; m++) begin
            {ia, id} = 2'(m);
            tick(2);
            ev_cnt = 0;
            heat(TRIP_TEMP);
            heat(8'h20);
            tick(2);
            check("alarm events", 8'(m / 2 + m % 2), 8'(ev_cnt));
        end
        power_state = PS_S0I1;
        heat(CRIT_TEMP);
        check("critical_trip_n", 8'h01, 8'(critical_trip_n));
        power_state = PS_C0;
        tick(2);
        check("critical_trip_n", 8'h00, 8'(critical_trip_n));
        check("core_shutdown", 8'h01, 8'(core_shutdown));
        heat(8'h20);
        check("critical_trip_n", 8'h00, 8'(critical_trip_n));
        tick(50);
        check("vcc_core_on", 8'h00, 8'(vcc_core_on));
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(2);
        check("critical_trip_n", 8'h01, 8'(critical_trip_n));
        give_verdict();
    end
endmodule

// >>> verilog/dtt_duty_mod.sv
`timescale 1ns/1ps
module dtt_duty_mod (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic run,
    input wire logic [2:0] duty,
    output logic clk_on
);
    import dtt_pkg::*;

    // ************************************************************
    // Eight-slot gating pattern, duty counts slots with clocks on.
    // ************************************************************
    typedef struct packed {
        logic [MOD_SLOT_W-1:0] slot;
        logic [2:0] eighth;
        logic on;
    } dtt_mod_t;

    dtt_mod_t s;
    dtt_mod_t next_s;

    always_comb begin
        next_s = s;
        if (!run) begin
            next_s.slot = '0;
            next_s.eighth = 3'h0;
            next_s.on = 1'b1;
        end else begin
            if (s.slot == MOD_SLOT_W'(MOD_SLOT_CYCLES - 1)) begin
                next_s.slot = '0;
                next_s.eighth = s.eighth + 3'h1;
            end else begin
                next_s.slot = s.slot + MOD_SLOT_W'(1);
            end
            next_s.on = (next_s.eighth < duty);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{slot: '0, eighth: 3'h0, on: 1'b1};
        end else begin
            s <= next_s;
        end
    end

    assign clk_on = s.on;

endmodule

// >>> verilog/dtt_pkg.sv
package dtt_pkg;

    // ************************************************************
    // Clock and timing.
    // ************************************************************
    localparam int CLK_PERIOD_NS = 10;
    localparam int FORCE_WAIT_NS = 1000;
    localparam int FORCE_WAIT_CYCLES = (FORCE_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FORCE_CNT_W = 8;
    localparam int MOD_SLOT_CYCLES = 4;
    localparam int MOD_SLOT_W = 4;

    // ************************************************************
    // Fixed temperature thresholds, in sensor code units.
    // ************************************************************
    localparam logic [7:0] TRIP_TEMP = 8'h5a;
    localparam logic [7:0] HYST_TEMP = 8'h03;
    localparam logic [7:0] RELEASE_TEMP = TRIP_TEMP - HYST_TEMP;
    localparam logic [7:0] CRIT_TEMP = 8'h7d;

    // ************************************************************
    // Operating points and duty codes.
    // ************************************************************
    localparam logic [3:0] LOWEST_POINT = 4'h1;
    localparam logic [3:0] OP_POINT_RESET = 4'h1;
    localparam logic [2:0] AUTO_DUTY = 3'h4;

    // ************************************************************
    // Throttle control field positions.
    // ************************************************************
    localparam int CTRL_ON_DEMAND_BIT = 4;
    localparam int CTRL_DUTY_LSB = 1;
    localparam int CTRL_DUTY_MSB = 3;

    // ************************************************************
    // Power states and throttle states.
    // ************************************************************
    typedef enum logic [2:0] {
        PS_C0 = 3'h0,
        PS_C1 = 3'h1,
        PS_C2 = 3'h2,
        PS_C4 = 3'h3,
        PS_C6 = 3'h4,
        PS_S0I1 = 3'h5,
        PS_S0I3 = 3'h6
    } dtt_power_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_MOD = 5'h02,
        ST_DROP = 5'h04,
        ST_DROP_MOD = 5'h08,
        ST_TRIP = 5'h10
    } dtt_state_t;

endpackage

// >>> verilog/dtt_throttle.sv
`timescale 1ns/1ps
module dtt_throttle (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [7:0] die_temp,
    input wire logic clock_modulation_mode,
    input wire logic frequency_drop_mode,
    input wire logic force_modulation_with_drop,
    input wire logic [4:0] throttle_ctrl,
    input wire logic alarm_irq_on_assert,
    input wire logic alarm_irq_on_deassert,
    input wire dtt_pkg::dtt_power_t power_state,
    input wire logic [3:0] sw_op_point,
    input wire logic sw_op_req,
    input wire logic irq_req,
    input wire logic irq_taken,
    input wire logic thermal_alarm_n_in,
    output logic thermal_alarm_n_out,
    output logic thermal_alarm_n_oe,
    output logic critical_trip_n,
    output logic core_shutdown,
    output logic core_clk_en,
    output logic snoop_active,
    output logic irq_to_core,
    output logic [3:0] op_point,
    output logic op_point_change,
    output logic alarm_event,
    output logic thermal_throttle_unit,
    output dtt_pkg::dtt_state_t throttle_state
);
    import dtt_pkg::*;

    // ************************************************************
    // State of the block.
    // ************************************************************
    typedef struct packed {
        dtt_state_t st;
        logic hot;
        logic alarm_sync1;
        logic alarm_sync2;
        logic alarm_drive;
        logic drive_d1;
        logic drive_d2;
        logic alarm_event;
        logic irq_latched;
        logic mod_auto;
        logic trip;
        logic [3:0] last_req;
        logic [3:0] op_point;
        logic op_change;
        logic [FORCE_CNT_W-1:0] force_cnt;
    } dtt_regs_t;

    dtt_regs_t s;
    dtt_regs_t next_s;

    logic mod_on;
    logic mod_run;
    logic [2:0] duty_sel;
    logic alarm_in_ok;
    logic alarm_out_ok;
    logic trip_ok;
    logic ext_hot;
    logic own_echo;
    logic hot_next;
    logic auto_en;
    logic auto_hot;
    logic on_demand;
    logic force_due;
    logic drop_now;
    logic [2:0] ctrl_duty;

    // ************************************************************
    // Power state and throttle drop state decoding.
    // ************************************************************
    function automatic logic awake_state(input dtt_power_t ps);
        awake_state = (ps == PS_C0) || (ps == PS_C1) || (ps == PS_C2);
    endfunction

    function automatic logic drop_state(input dtt_state_t st);
        drop_state = (st == ST_DROP) || (st == ST_DROP_MOD);
    endfunction

    // ************************************************************
    // Helper functions.
    // ************************************************************
    function automatic logic mod_state(input dtt_state_t st);
        mod_state = (st == ST_MOD) || (st == ST_DROP_MOD);
    endfunction

    function automatic logic hyst_flag(input logic [7:0] temp, input logic held);
        if (temp >= TRIP_TEMP) begin
            hyst_flag = 1'b1;
        end else if (temp < RELEASE_TEMP) begin
            hyst_flag = 1'b0;
        end else begin
            hyst_flag = held;
        end
    endfunction

    function automatic logic edge_event(input logic was, input logic now, input logic rise_en, input logic fall_en);
        edge_event = (now && !was && rise_en) || (!now && was && fall_en);
    endfunction

    function automatic logic [FORCE_CNT_W-1:0] force_count(input logic in_drop, input logic hot,
        input logic [FORCE_CNT_W-1:0] cnt);
        if (!in_drop || !hot) begin
            force_count = '0;
        end else if (cnt != FORCE_CNT_W'(FORCE_WAIT_CYCLES)) begin
            force_count = cnt + FORCE_CNT_W'(1);
        end else begin
            force_count = cnt;
        end
    endfunction

    always_comb begin
        alarm_in_ok = awake_state(power_state);
        alarm_out_ok = awake_state(power_state);
        trip_ok = awake_state(power_state) || (power_state == PS_C4) || (power_state == PS_C6);
    end

    // ************************************************************
    // Modulation pattern generator.
    // ************************************************************
    assign mod_run = mod_state(s.st);
    assign ctrl_duty = throttle_ctrl[CTRL_DUTY_MSB:CTRL_DUTY_LSB];

    always_comb begin
        if (s.mod_auto || ctrl_duty == 3'h0) begin
            duty_sel = AUTO_DUTY;
        end else begin
            duty_sel = ctrl_duty;
        end
    end

    dtt_duty_mod u_duty (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .run(mod_run),
        .duty(duty_sel),
        .clk_on(mod_on)
    );

    // ************************************************************
    // Alarm pin input qualification.
    // ************************************************************
    always_comb begin
        // our own drive echoes back through the synchroniser, so it is masked.
        own_echo = s.alarm_drive || s.drive_d1 || s.drive_d2;
        hot_next = hyst_flag(die_temp, s.hot);
        ext_hot = alarm_in_ok && !s.alarm_sync2 && !own_echo;
        auto_en = clock_modulation_mode || frequency_drop_mode;
        auto_hot = auto_en && (s.hot || ext_hot);
        on_demand = throttle_ctrl[CTRL_ON_DEMAND_BIT];
        force_due = force_modulation_with_drop && clock_modulation_mode && s.hot
                    && (s.force_cnt == FORCE_CNT_W'(FORCE_WAIT_CYCLES));
        drop_now = auto_hot && frequency_drop_mode;
    end

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        next_s = s;
        next_s.alarm_sync1 = thermal_alarm_n_in;
        next_s.alarm_sync2 = s.alarm_sync1;
        next_s.op_change = 1'b0;
        next_s.alarm_event = 1'b0;

        next_s.hot = hot_next;
        next_s.drive_d1 = s.alarm_drive;
        next_s.drive_d2 = s.drive_d1;
        next_s.force_cnt = force_count(drop_state(s.st), s.hot, s.force_cnt);

        case (s.st)
            ST_IDLE, ST_MOD, ST_DROP, ST_DROP_MOD: begin
                if (drop_now) begin
                    if (force_due || (s.st == ST_DROP_MOD && s.hot && force_modulation_with_drop)) begin
                        next_s.st = ST_DROP_MOD;
                        next_s.mod_auto = 1'b1;
                    end else begin
                        next_s.st = ST_DROP;
                        next_s.mod_auto = 1'b0;
                    end
                end else if (auto_hot) begin
                    next_s.st = ST_MOD;
                    next_s.mod_auto = 1'b1;
                end else if (on_demand) begin
                    next_s.st = ST_MOD;
                    next_s.mod_auto = 1'b0;
                end else begin
                    next_s.st = ST_IDLE;
                    next_s.mod_auto = 1'b0;
                end
            end
            ST_TRIP: begin
                next_s.st = ST_TRIP;
            end
            default: begin
                next_s.st = ST_IDLE;
            end
        endcase

        // ********************************************************
        // Operating point handling.
        // ********************************************************
        if (sw_op_req) begin
            next_s.last_req = sw_op_point;
        end
        if (drop_state(next_s.st)) begin
            if (!drop_state(s.st)) begin
                next_s.op_point = LOWEST_POINT;
            end
            if (sw_op_req && sw_op_point < LOWEST_POINT) begin
                next_s.op_point = sw_op_point;
            end
            if (sw_op_req && sw_op_point >= LOWEST_POINT && s.op_point < LOWEST_POINT) begin
                next_s.op_point = LOWEST_POINT;
            end
        end else if (drop_state(s.st) && next_s.st != ST_TRIP) begin
            next_s.op_point = next_s.last_req;
        end else if (sw_op_req && s.st != ST_TRIP) begin
            next_s.op_point = sw_op_point;
        end
        next_s.op_change = (next_s.op_point != s.op_point);

        // ********************************************************
        // Hot alarm output and its event.
        // ********************************************************
        // alarm drive.
        next_s.alarm_drive = alarm_out_ok && next_s.hot && !s.trip;
        next_s.alarm_event = edge_event(s.alarm_drive, next_s.alarm_drive, alarm_irq_on_assert,
                                        alarm_irq_on_deassert);

        // ********************************************************
        // Interrupt latch and critical trip.
        // ********************************************************
        // latch, set wins over clear.
        if (irq_req) begin
            next_s.irq_latched = 1'b1;
        end else if (irq_taken && irq_to_core) begin
            next_s.irq_latched = 1'b0;
        end

        if (trip_ok && die_temp >= CRIT_TEMP) begin
            next_s.trip = 1'b1;
            next_s.st = ST_TRIP;
            next_s.alarm_drive = 1'b0;
        end
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            s <= '{st: ST_IDLE, hot: 1'b0, alarm_sync1: 1'b1, alarm_sync2: 1'b1,
                   alarm_drive: 1'b0, drive_d1: 1'b0, drive_d2: 1'b0, alarm_event: 1'b0, irq_latched: 1'b0,
                   mod_auto: 1'b0, trip: 1'b0, last_req: OP_POINT_RESET,
                   op_point: OP_POINT_RESET, op_change: 1'b0, force_cnt: '0};
        end else begin
            s <= next_s;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign thermal_alarm_n_out = 1'b0;
    assign thermal_alarm_n_oe = s.alarm_drive;
    assign critical_trip_n = !s.trip;
    assign core_shutdown = s.trip;
    assign core_clk_en = !s.trip && (!mod_run || mod_on);
    assign snoop_active = !s.trip;
    assign irq_to_core = s.irq_latched && core_clk_en;
    assign op_point = s.op_point;
    assign op_point_change = s.op_change;
    assign alarm_event = s.alarm_event;
    assign thermal_throttle_unit = (s.st != ST_IDLE) && (s.st != ST_TRIP);
    assign throttle_state = s.st;

endmodule
